/* File: design/dsw_port.v */
/*
 Write-only serial command port of a single-channel voltage-output DAC, with input and
 output registers and a load strobe.
 A select-framed sixteen-bit word is shifted in by the shifter stage, checked for its
 command bit and split into gain, shutdown and code fields for the input register.
 A one-hot load tracker decides when the output register copies the input register.
 Narrow variants zero the unused low code bits instead of storing them.
 Assumes all pins are synchronous to clk and free of metastability; the serial clock
 stays high and low for at least two clk cycles each.
 Assumes the analog side consumes the output register fields and needs no handshake.
 Assumes the host is idle while ce is low, since a frame seen only in part is dropped or, if its select fall is missed, can latch a stale word.
*/
// Overview of operation
// - Words with bit 15 set are dropped; bit 14 is don't-care.
// - Bit 13 selects gain: one gives unity, zero gives double.
// - Bit 12 is active-low shutdown; zero powers output down.
// - Code comes from bits 11..0; unused low bits are not stored.
// - Ten-bit variant: code in bits 11..2, bits 1..0 ignored.
// - Eight-bit variant: code in bits 11..4, bits 3..0 ignored.
// - Three wires in: select, clock, data; nothing goes back.
// - Load-output low copies input register into output register once a first valid word has been accepted.
// - Load tied low updates output right after a valid word completes.
// - Reset forces shutdown bit to zero.
// - Four configuration bits then twelve data bits, sampled on rising clock.
// - Word latched at select rise only after sixteen clocks.
// - Clocks beyond sixteen in one frame are ignored.
// - Clock may idle low or high; sampling always on rising edge.
`timescale 1ns/1ns
`include "dsw_defines.vh"
module dsw_port #(
	parameter RESOLUTION = `DSW_RES_12
) (
	// Clock, reset, enable
	input wire clk,
	input wire rstn,
	input wire ce,
	// Serial link
	input wire cs_n,
	input wire sck,
	input wire sdi,
	// Load strobe
	input wire load_output_n,
	// Output register to analog side
	output reg [`DSW_CODE_MSB:0] dac_code_reg,
	output reg gain_select_n_reg,
	output reg output_shutdown_n_reg,
	output reg out_update_reg,
	// Input register view
	output reg in_valid_reg
);
	localparam LOW_BITS = `DSW_CODE_MSB + 1 - RESOLUTION;

	reg sck_d_reg;
	reg cs_d_reg;
	reg [`DSW_CODE_MSB:0] in_code_reg;
	reg in_gain_reg;
	reg in_output_shutdown_n_reg;
	wire [`DSW_WORD_BITS-1:0] word;
	wire word_done;
	wire [`DSW_CODE_MSB:0] code_mask;

	// Load tracker states, one-hot
	localparam LD_EMPTY = 3'b001;
	localparam LD_HELD = 3'b010;
	localparam LD_FOLLOW = 3'b100;
	reg [2:0] ld_state_reg;
	reg [2:0] ld_state_next;

	// Next values
	reg sck_d_next;
	reg cs_d_next;
	reg [`DSW_CODE_MSB:0] in_code_next;
	reg in_gain_next;
	reg in_output_shutdown_n_next;
	reg in_valid_next;
	reg [`DSW_CODE_MSB:0] dac_code_next;
	reg gain_select_n_next;
	reg output_shutdown_n_next;
	reg out_update_next;

	// Decoded word and load qualifiers
	wire word_gain;
	wire word_output_shutdown_n;
	wire [`DSW_CODE_MSB:0] word_code;
	wire accept;
	wire ld_armed;
	wire load_now;

	// Rising clock sampling works for either idle level
	wire sck_rise = sck & ~sck_d_reg;
	wire cs_fall = cs_d_reg & ~cs_n;
	wire cs_rise = ~cs_d_reg & cs_n;
	// Only the three inputs feed the shifter; no output goes back
	wire cs_low = ~cs_n;

	// Low code bits of narrower variants are forced to zero, not stored
	genvar gi;
	generate
		for (gi = 0; gi <= `DSW_CODE_MSB; gi = gi + 1) begin : g_mask
			assign code_mask[gi] = (gi >= LOW_BITS);
		end
	endgenerate

	dsw_shifter #(
		.WORD_BITS(`DSW_WORD_BITS)
	) u_shift (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.sck_rise(sck_rise),
		.cs_fall(cs_fall),
		.cs_rise(cs_rise),
		.cs_low(cs_low),
		.sdi(sdi),
		.word_reg(word),
		.word_done_reg(word_done)
	);

	// A word with the command bit set is thrown away whole
	assign accept = word_done & ~word[`DSW_BIT_CMD];
	// Bit 14 is never looked at, so the host may send anything there
	assign word_gain = word[`DSW_BIT_GAIN];
	assign word_output_shutdown_n = word[`DSW_BIT_OUTPUT_SHUTDOWN_N];
	assign word_code = word[`DSW_CODE_MSB:`DSW_CODE_LSB] & code_mask;

	// Edge detector samples
	always @* begin
		sck_d_next = sck;
		cs_d_next = cs_n;
	end

	// Input register next values
	always @* begin
		in_code_next = in_code_reg;
		in_gain_next = in_gain_reg;
		in_output_shutdown_n_next = in_output_shutdown_n_reg;
		if (accept) begin
			in_gain_next = word_gain;
			in_output_shutdown_n_next = word_output_shutdown_n;
			in_code_next = word_code;
		end
	end

	// Nothing reaches the output before the first accepted word, so a tied-low strobe
	// keeps the output shut down until then
	always @* begin
		ld_state_next = ld_state_reg;
		case (ld_state_reg)
			LD_EMPTY: begin
				if (accept) begin
					ld_state_next = LD_HELD;
				end
			end
			LD_HELD: begin
				if (!load_output_n) begin
					ld_state_next = LD_FOLLOW;
				end
			end
			LD_FOLLOW: begin
				if (load_output_n) begin
					ld_state_next = LD_HELD;
				end
			end
			default: begin
				// An illegal code falls back to empty; the host only has to resend
				ld_state_next = LD_EMPTY;
			end
		endcase
		in_valid_next = |(ld_state_next & (LD_HELD | LD_FOLLOW));
	end

	// Level load: while low the output register follows the input register, so a tied-low
	// strobe updates one cycle after the word lands
	assign ld_armed = |(ld_state_reg & (LD_HELD | LD_FOLLOW));
	assign load_now = ~load_output_n & ld_armed;

	// Output register next values
	always @* begin
		dac_code_next = dac_code_reg;
		gain_select_n_next = gain_select_n_reg;
		output_shutdown_n_next = output_shutdown_n_reg;
		out_update_next = load_now;
		if (load_now) begin
			dac_code_next = in_code_reg;
			gain_select_n_next = in_gain_reg;
			output_shutdown_n_next = in_output_shutdown_n_reg;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sck_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
		end else if (ce) begin
			sck_d_reg <= sck_d_next;
			cs_d_reg <= cs_d_next;
		end
	end

	// Input register
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_code_reg <= `DSW_RST_CODE;
			in_gain_reg <= `DSW_RST_GAIN;
			in_output_shutdown_n_reg <= `DSW_RST_OUTPUT_SHUTDOWN_N;
			in_valid_reg <= 1'b0;
			ld_state_reg <= LD_EMPTY;
		end else if (ce) begin
			in_code_reg <= in_code_next;
			in_gain_reg <= in_gain_next;
			in_output_shutdown_n_reg <= in_output_shutdown_n_next;
			in_valid_reg <= in_valid_next;
			ld_state_reg <= ld_state_next;
		end
	end

	// Output register; ce low freezes it along with everything else
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dac_code_reg <= `DSW_RST_CODE;
			gain_select_n_reg <= `DSW_RST_GAIN;
			output_shutdown_n_reg <= `DSW_RST_OUTPUT_SHUTDOWN_N;
			out_update_reg <= 1'b0;
		end else if (ce) begin
			dac_code_reg <= dac_code_next;
			gain_select_n_reg <= gain_select_n_next;
			output_shutdown_n_reg <= output_shutdown_n_next;
			out_update_reg <= out_update_next;
		end
	end
endmodule

/* File: design/dsw_defines.vh */
/*
 Constants for the serial DAC write port: command word layout, reset values and counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH
`define DSW_WORD_BITS 16
`define DSW_CNT_BITS 5
`define DSW_BIT_CMD 15
`define DSW_BIT_DONTCARE 14
`define DSW_BIT_GAIN 13
`define DSW_BIT_OUTPUT_SHUTDOWN_N 12
`define DSW_CODE_MSB 11
`define DSW_CODE_LSB 0
`define DSW_RES_12 12
`define DSW_RES_10 10
`define DSW_RES_8 8
`define DSW_RST_OUTPUT_SHUTDOWN_N 1'b0
`define DSW_RST_GAIN 1'b0
`define DSW_RST_CODE 12'h000
`define DSW_RST_WORD 16'h0000
`endif

/* File: design/dsw_shifter.v */
/*
 Serial shift stage of the DAC write port: counts and captures the first sixteen bits of a
 frame and flags a complete word at the select rising edge.
 Assumes sck, cs_n and sdi are synchronous to clk and already edge-qualified by the caller.
*/
`timescale 1ns/1ns
`include "dsw_defines.vh"
module dsw_shifter #(
	parameter WORD_BITS = `DSW_WORD_BITS
) (
	// Clock, reset, enable
	input wire clk,
	input wire rstn,
	input wire ce,
	// Qualified events
	input wire sck_rise,
	input wire cs_fall,
	input wire cs_rise,
	input wire cs_low,
	input wire sdi,
	// Captured word
	output reg [WORD_BITS-1:0] word_reg,
	output reg word_done_reg
);
	reg [WORD_BITS-1:0] shift_reg;
	reg [`DSW_CNT_BITS-1:0] count_reg;
	wire full = (count_reg == WORD_BITS[`DSW_CNT_BITS-1:0]);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_reg <= `DSW_RST_WORD;
			count_reg <= 5'h00;
			word_reg <= `DSW_RST_WORD;
			word_done_reg <= 1'b0;
		end else if (ce) begin
			word_done_reg <= 1'b0;
			if (cs_fall) begin
				count_reg <= 5'h00;
			end else if (cs_low && sck_rise && !full) begin
				// First bit in lands at bit 15 after sixteen shifts
				shift_reg <= {shift_reg[WORD_BITS-2:0], sdi};
				count_reg <= count_reg + 5'h01;
			end
			// Extra clocks beyond sixteen are ignored above
			if (cs_rise && full) begin
				word_reg <= shift_reg;
				word_done_reg <= 1'b1;
			end
		end
	end
endmodule

/* File: tb/dsw_port_properties.sv */
/*
 Checker for the serial DAC write port.
 Assumes the top module's ports only; bound below.
*/
`timescale 1ns/1ns
module dsw_props #(
	parameter RESOLUTION = 12
) (
	input logic clk, rstn, ce, cs_n, sck, sdi, load_output_n,
	input logic [11:0] dac_code_reg,
	input logic gain_select_n_reg, output_shutdown_n_reg, out_update_reg, in_valid_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_code; $changed(dac_code_reg) |-> out_update_reg; endproperty
	a_code: assert property(p_code) else $error("code moved");
	property p_gain; $changed(gain_select_n_reg) |-> out_update_reg; endproperty
	a_gain: assert property(p_gain) else $error("gain moved");
	property p_output_shutdown_n; $changed(output_shutdown_n_reg) |-> out_update_reg; endproperty
	a_output_shutdown_n: assert property(p_output_shutdown_n) else $error("output_shutdown_n moved");
	property p_rst; !in_valid_reg |-> !output_shutdown_n_reg && !out_update_reg; endproperty
	a_rst: assert property(p_rst) else $error("not shut");
	property p_low; (dac_code_reg & ((12'h1 << (12 - RESOLUTION)) - 1)) == 0; endproperty
	a_low: assert property(p_low) else $error("low bits");
	property p_word; $rose(in_valid_reg) |-> $past(cs_n, 2) && !$past(cs_n, 3); endproperty
	a_word: assert property(p_word) else $error("word time");
	property p_upd;
		out_update_reg && $past(ce) |-> !$past(load_output_n) && in_valid_reg;
	endproperty
	a_upd: assert property(p_upd) else $error("upd cause");
	property p_hold;
		load_output_n && $past(load_output_n) && $past(ce) |-> !out_update_reg;
	endproperty
	a_hold: assert property(p_hold) else $error("no hold");
	c_vld: cover property($rose(in_valid_reg));
	c_upd: cover property($rose(out_update_reg));
	c_hold: cover property(load_output_n && in_valid_reg);
endmodule
bind dsw_port dsw_props #(.RESOLUTION(RESOLUTION)) u_props(.*);

/* File: tb/dsw_host_model.sv */
/*
 Serial host model: drives select, clock and data.
 Assumes a free-running clk; idle clock level chosen per frame.
*/
`timescale 1ns/1ns
module dsw_host_model (
	input logic clk,
	output logic cs_n = 1'b1, sck = 1'b0, sdi = 1'b0
);
	// Only drives; nothing comes back
	task send(input logic [15:0] w, input int n, input logic pol);
		// Idle level settles while select is still high, as a real host would
		@(posedge clk) sck <= pol;
		repeat (2) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (2) @(posedge clk);
			sck <= 1'b0;
			sdi <= (i < 16) ? w[15 - i] : ~sdi;
			repeat (2) @(posedge clk);
			sck <= 1'b1;
		end
		repeat (2) @(posedge clk);
		sck <= pol;
		cs_n <= 1'b1;
		sdi <= ~sdi; // Released line must not keep its value
		repeat (2) @(posedge clk);
	endtask
endmodule

/* File: tb/dsw_port_tb.sv */
/*
 Testbench for the serial DAC write port, ten-bit variant.
 Assumes the host model drives all serial pins.
*/
`timescale 1ns/1ns
module dsw_port_tb;
	logic clk = 0, rstn = 0, ce = 1, load_output_n = 0, cs_n, sck, sdi, g, s, upd, vld;
	logic [11:0] code;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	always #5 clk = ~clk;
	dsw_host_model u_host(.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi));
	dsw_port #(.RESOLUTION(10)) dut(.clk(clk), .rstn(rstn), .ce(ce), .cs_n(cs_n), .sck(sck),
		.sdi(sdi), .load_output_n(load_output_n), .dac_code_reg(code), .gain_select_n_reg(g),
		.output_shutdown_n_reg(s), .out_update_reg(upd), .in_valid_reg(vld));
	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [13:0] e);
		cmp_count++;
		if ({g, s, code} !== e) begin
			fail_count++;
			$display("unexpected at %0t exp %h got %h", $time, e, {g, s, code});
		end
	endtask
	task chk_flags(input logic [1:0] e);
		cmp_count++;
		if ({vld, upd} !== e) begin
			fail_count++;
			$display("unexpected at %0t exp %h got %h", $time, e, {vld, upd});
		end
	endtask
	task frame(input logic [15:0] w, input int n, input logic p);
		u_host.send(w, n, p);
		repeat (5) @(posedge clk);
	endtask
	task t_tied;
		frame(16'h3abf, 16, 0);
		chk(14'h3abc);
		chk_flags(2'h3);
		$display("t_tied done");
	endtask
	task t_drop;
		frame(16'h9123, 16, 1);
		chk(14'h3abc);
		frame(16'h1555, 15, 0);
		chk(14'h3abc);
		frame(16'h5555, 20, 1);
		chk(14'h1554);
		$display("t_drop done");
	endtask
	task t_load;
		load_output_n <= 1'b1;
		frame(16'h2fff, 16, 0);
		chk(14'h1554);
		chk_flags(2'h2);
		load_output_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk(14'h2ffc);
		chk_flags(2'h3);
		$display("t_load done");
	endtask
	task t_freeze;
		ce <= 1'b0;
		frame(16'h3000, 16, 0);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk(14'h2ffc);
		$display("t_freeze done");
	endtask
	always @(posedge clk) if (++cyc == 2000) begin
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(14'h0000);
		chk_flags(2'h0);
		t_tied;
		t_drop;
		t_load;
		t_freeze;
		report_and_stop;
	end
endmodule
